// ===== rtl/pdsr_top.sv
// APB register bank, interrupt logic and loopback data paths for two copper ports
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
`include "pdsr_defs.svh"
module pdsr_top #(
  parameter int NPORT = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,

  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,

  // Interrupt
  output logic irq,

  // Cable tester per copper port
  output logic [NPORT-1:0] diag_run,
  output logic [2*NPORT-1:0] diag_pair,
  input pdsr_pkg::pdsr_diag_ans_t [NPORT-1:0] diag_ans,

  // Link state per copper port
  input wire logic [NPORT-1:0] link_gig,
  input wire logic [NPORT-1:0] link_fast,

  // Copper line data per port
  input pdsr_pkg::pdsr_beat_t [NPORT-1:0] line_rx,
  output pdsr_pkg::pdsr_beat_t [NPORT-1:0] line_tx,

  // Fabric side per copper port
  input pdsr_pkg::pdsr_beat_t [NPORT-1:0] fab_tx,
  output pdsr_pkg::pdsr_beat_t [NPORT-1:0] fab_rx,

  // External MAC port pins and fabric side
  input pdsr_pkg::pdsr_beat_t xmac_txd,
  output pdsr_pkg::pdsr_beat_t xmac_rxd,
  input pdsr_pkg::pdsr_beat_t xfab_tx,
  output pdsr_pkg::pdsr_beat_t xfab_rx
);

  // Events per port: test done, link change, saturation
  localparam int NEV = 3;
  localparam int NIRQ = NEV * NPORT;
  // Idle beat: valid low, all fields zero
  localparam pdsr_pkg::pdsr_beat_t IDLE_BEAT = '0;

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  // Bus answer
  logic [31:0] prdata_q, prdata_d;
  logic pready_q;
  logic pslverr_q, pslverr_d;
  logic [15:0] last_rd_q;

  // Interrupt state
  logic irq_q;
  logic [NIRQ-1:0] ist_q, ist_d;
  logic [NIRQ-1:0] imask_q, imask_d;
  logic [NIRQ-1:0] ev;

  // External MAC loopback
  logic [15:0] xlb_q, xlb_d;

  // Registered tester controls
  logic [NPORT-1:0] run_q;
  logic [2*NPORT-1:0] pair_q;

  // Data path registers and next values
  pdsr_pkg::pdsr_beat_t [NPORT-1:0] line_tx_q, fab_rx_q;
  pdsr_pkg::pdsr_beat_t [NPORT-1:0] tx_sel_v, rx_sel_v;
  pdsr_pkg::pdsr_beat_t xmac_rxd_q, xfab_rx_q;

  // Per-port results
  logic [NPORT-1:0] loop_en;
  logic [NPORT-1:0] p_run;
  logic [2*NPORT-1:0] p_pair;
  logic [15:0] p_rdata [NPORT];
  logic [NPORT-1:0] p_hit;
  pdsr_pkg::pdsr_wreq_t [NPORT-1:0] p_wreq;
  logic [NPORT-1:0] p_rdclr;

  // ----------------------------------------------------------------------------
  // APB phase decode
  // ----------------------------------------------------------------------------
  // Setup cycle loads read data; access cycle completes with pready from a flop
  // Every transfer takes one access cycle, never a wait.
  // Side effects act only at the completing edge.
  wire [15:0] idx = paddr[17:2];
  wire [3:0] port_nib = idx[15:12];
  wire setup = psel && !penable;
  wire done = psel && penable && pready_q;
  wire wr_done = done && pwrite;
  wire rd_done = done && !pwrite;

  // Map: two port windows plus own words
  wire [15:0] wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  wire is_port = (port_nib >= `PDSR_PORT_FIRST) && (port_nib <= `PDSR_PORT_LAST);
  wire [3:0] port_sel = port_nib - `PDSR_PORT_FIRST;
  wire hit_ist = (idx == `PDSR_IDX_IRQ_STATUS);
  wire hit_imask = (idx == `PDSR_IDX_IRQ_MASK);
  wire hit_xlb = (idx == `PDSR_IDX_XMAC_LOOPBACK);

  // Any hit answers without error
  wire port_hit = is_port && p_hit[port_sel[0]];
  wire mapped = hit_ist || hit_imask || hit_xlb || port_hit;
  wire rx_cnt_sel = (idx[11:0] == `PDSR_IDX_RX_SYM_ERR);

  // ----------------------------------------------------------------------------
  // Per-port register sets
  // ----------------------------------------------------------------------------
  // One instance per copper port; the upper address nibble picks it
  // Missing port windows answer with a bus error.
  for (genvar g = 0; g < NPORT; g++) begin : g_port
    wire port_me = is_port && (port_sel == 4'(g));
    // Writes reach a port only at completion
    assign p_wreq[g].idx = idx[11:0];
    assign p_wreq[g].wr = wr_done && port_me;
    assign p_wreq[g].wdata = pwdata[15:0];
    assign p_wreq[g].wmask = wmask;
    // Read-clear only for this port's counter
    assign p_rdclr[g] = rd_done && port_me && rx_cnt_sel;

    pdsr_port u_port (
      .pclk(pclk),
      .presetn(presetn),
      .wreq(p_wreq[g]),
      .rd_clr(p_rdclr[g]),
      .clr_val(last_rd_q),
      .rd_data(p_rdata[g]),
      .rd_hit(p_hit[g]),
      .diag_ans(diag_ans[g]),
      .link_gig(link_gig[g]),
      .link_fast(link_fast[g]),
      .line_rx(line_rx[g]),
      .loop_en(loop_en[g]),
      .diag_run(p_run[g]),
      .diag_pair(p_pair[2*g +: 2]),
      .events(ev[NEV*g +: NEV])
    );

    // Loopback turns the line receive beat straight round and starves the fabric
    assign tx_sel_v[g] = loop_en[g] ? line_rx[g] : fab_tx[g];
    assign rx_sel_v[g] = loop_en[g] ? IDLE_BEAT : line_rx[g];
  end

  // One register process for all copper paths
  // The fabric never sees a frame being echoed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_tx_q <= '0;
      fab_rx_q <= '0;
    end else begin
      line_tx_q <= tx_sel_v;
      fab_rx_q <= rx_sel_v;
    end
  end

  // ----------------------------------------------------------------------------
  // External MAC port loopback
  // ----------------------------------------------------------------------------
  // Transmit pins come back out on the receive pins; the fabric sees idle
  // Loopback acts one cycle after the write
  wire xloop = xlb_q[`PDSR_LB_BIT];
  wire pdsr_pkg::pdsr_beat_t xrxd_sel = xloop ? xmac_txd : xfab_tx;
  wire pdsr_pkg::pdsr_beat_t xfab_sel = xloop ? IDLE_BEAT : xmac_txd;

  // Low two bits always read zero
  wire [15:0] xlb_keep = xlb_q & ~(wmask & `PDSR_LB_WMASK);
  wire [15:0] xlb_new = pwdata[15:0] & wmask & `PDSR_LB_WMASK;
  assign xlb_d = (wr_done && hit_xlb) ? (xlb_keep | xlb_new) : xlb_q;

  // Reset leaves external loopback off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xlb_q <= `PDSR_LB_RST;
      xmac_rxd_q <= IDLE_BEAT;
      xfab_rx_q <= IDLE_BEAT;
    end else begin
      xlb_q <= xlb_d;
      xmac_rxd_q <= xrxd_sel;
      xfab_rx_q <= xfab_sel;
    end
  end

  // ----------------------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------------------
  // Write one clears; an event in the same cycle keeps its bit set
  // All status bits sit in byte lane 0.
  // Masked events stay sticky for a later unmask.
  wire [NIRQ-1:0] ist_clr = (wr_done && hit_ist && pstrb[0]) ? pwdata[NIRQ-1:0] : '0;
  assign ist_d = (ist_q & ~ist_clr) | ev;
  assign imask_d = (wr_done && hit_imask && pstrb[0]) ? pwdata[NIRQ-1:0] : imask_q;

  // Next values, so irq tracks status without lag
  wire irq_d = |(ist_d & imask_d);

  // Status, mask and irq in one process
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= '0;
      imask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      ist_q <= ist_d;
      imask_q <= imask_d;
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Read data and answer
  // ----------------------------------------------------------------------------
  // Read value is taken at setup; the counter later subtracts exactly that value
  // prdata stays put even if the counter moves;
  // frames counted meanwhile are kept.
  wire [15:0] port_rd = p_rdata[port_sel[0]];
  wire [15:0] rd_word = hit_ist ? {{(16-NIRQ){1'b0}}, ist_q} :
    hit_imask ? {{(16-NIRQ){1'b0}}, imask_q} :
    hit_xlb ? xlb_q :
    port_hit ? port_rd : 16'h0000;

  // Error flag lives only with pready; no gate at the pin
  assign prdata_d = setup ? {16'h0000, rd_word} : prdata_q;
  assign pslverr_d = setup ? !mapped : 1'b0;

  // last_rd_q holds what the counter will subtract
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      last_rd_q <= `PDSR_CNT_RST;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= setup;
      pslverr_q <= pslverr_d;
      if (setup) last_rd_q <= rd_word;
    end
  end

  // Tester controls are registered so that every output leaves a flop
  // Harmless delay: the tester starts on a level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= '0;
      pair_q <= '0;
    end else begin
      run_q <= p_run;
      pair_q <= p_pair;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  // Every output is a plain register copy
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign diag_run = run_q;
  assign diag_pair = pair_q;

  // Data paths, one cycle behind their inputs
  assign line_tx = line_tx_q;
  assign fab_rx = fab_rx_q;
  assign xmac_rxd = xmac_rxd_q;
  assign xfab_rx = xfab_rx_q;

  // Limitation: port select uses one bit, so a third
  // copper port needs a wider select; beats must
  // already be in the bus clock domain.

endmodule : pdsr_top

// ===== rtl/pdsr_defs.svh
// Register offsets, field positions, reset values and codes of the diagnostic/status bank
`ifndef PDSR_DEFS_SVH
`define PDSR_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define PDSR_IDX_EXT_CAP 12'h11e
`define PDSR_IDX_LOOPBACK 12'h122
`define PDSR_IDX_CABLE_DIAG 12'h124
`define PDSR_IDX_LINE_LINK 12'h126
`define PDSR_IDX_RX_SYM_ERR 12'h12a
`define PDSR_IDX_IRQ_STATUS 16'h0f00
`define PDSR_IDX_IRQ_MASK 16'h0f02
`define PDSR_IDX_XMAC_LOOPBACK 16'h0f04
`define PDSR_PORT_FIRST 4'h1
`define PDSR_PORT_LAST 4'h2

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PDSR_CAP_XFD_BIT 15
`define PDSR_CAP_XHD_BIT 14
`define PDSR_CAP_TFD_BIT 13
`define PDSR_CAP_THD_BIT 12
`define PDSR_LB_BIT 8
`define PDSR_DIAG_EN_BIT 15
`define PDSR_DIAG_RSV_BIT 14
`define PDSR_DIAG_PAIR_HI 13
`define PDSR_DIAG_PAIR_LO 12
`define PDSR_DIAG_RSV2_HI 11
`define PDSR_DIAG_RSV2_LO 10
`define PDSR_DIAG_RES_HI 9
`define PDSR_DIAG_RES_LO 8
`define PDSR_LINK_GIG_BIT 1
`define PDSR_LINK_FAST_BIT 0
`define PDSR_EV_DIAG_DONE 0
`define PDSR_EV_LINK_CHG 1
`define PDSR_EV_CNT_SAT 2

// ----------------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------------
`define PDSR_LB_RST 16'h00f4
`define PDSR_LB_WMASK 16'hfffc
`define PDSR_PAIR_RST 2'h0
`define PDSR_RES_NONE 2'h0
`define PDSR_RES_RSVD 2'h3
`define PDSR_CNT_RST 16'h0000
`define PDSR_CNT_MAX 16'hffff

`endif

// ===== rtl/pdsr_pkg.sv
// Types shared by the diagnostic/status bank
package pdsr_pkg;

  // One data beat on a loopback-capable path
  typedef struct packed {
    logic valid;
    logic last;
    logic err;
    logic [7:0] data;
  } pdsr_beat_t;

  // Register write request to one port
  typedef struct packed {
    logic [11:0] idx;
    logic wr;
    logic [15:0] wdata;
    logic [15:0] wmask;
  } pdsr_wreq_t;

  // Cable tester answer
  typedef struct packed {
    logic done;
    logic [1:0] result;
  } pdsr_diag_ans_t;

  // Engine states of the cable test
  typedef enum logic [1:0] {
    PDSR_DIAG_IDLE = 2'b01,
    PDSR_DIAG_RUN = 2'b10
  } pdsr_diag_st_t;

endpackage : pdsr_pkg

// ===== rtl/pdsr_port.sv
// Per-port register set: loopback, cable test, link status, symbol-error counter
`timescale 1ns/100ps
`include "pdsr_defs.svh"
module pdsr_port (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register access
  input pdsr_pkg::pdsr_wreq_t wreq,
  input wire logic rd_clr,
  input wire logic [15:0] clr_val,
  output logic [15:0] rd_data,
  output logic rd_hit,
  // Port core side
  input pdsr_pkg::pdsr_diag_ans_t diag_ans,
  input wire logic link_gig,
  input wire logic link_fast,
  input pdsr_pkg::pdsr_beat_t line_rx,
  // Control and events
  output logic loop_en,
  output logic diag_run,
  output logic [1:0] diag_pair,
  output logic [2:0] events
);

  logic [15:0] lb_q, lb_d;
  pdsr_pkg::pdsr_diag_st_t st_q, st_d;
  logic [4:0] dctl_q, dctl_d;
  logic [1:0] res_q, res_d;
  logic [1:0] link_q;
  logic [15:0] cnt_q, cnt_d;
  logic ferr_q;
  logic [16:0] cnt_sum;
  logic frame_bad;

  // ----------------------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------------------
  wire wr_lb = wreq.wr && (wreq.idx == `PDSR_IDX_LOOPBACK);
  wire wr_diag = wreq.wr && (wreq.idx == `PDSR_IDX_CABLE_DIAG);
  wire [15:0] lb_keep = lb_q & ~(wreq.wmask & `PDSR_LB_WMASK);
  wire [15:0] lb_new = wreq.wdata & wreq.wmask & `PDSR_LB_WMASK;
  wire hi_lane = wreq.wmask[`PDSR_DIAG_EN_BIT];
  wire diag_start = wr_diag && hi_lane && wreq.wdata[`PDSR_DIAG_EN_BIT];
  wire diag_stop = wr_diag && hi_lane && !wreq.wdata[`PDSR_DIAG_EN_BIT];
  wire finished = (st_q == pdsr_pkg::PDSR_DIAG_RUN) && diag_ans.done;

  // Loopback and static control fields
  assign lb_d = wr_lb ? (lb_keep | lb_new) : lb_q;
  assign dctl_d = (wr_diag && hi_lane) ?
    {wreq.wdata[`PDSR_DIAG_RSV_BIT], wreq.wdata[`PDSR_DIAG_PAIR_HI:`PDSR_DIAG_PAIR_LO],
     wreq.wdata[`PDSR_DIAG_RSV2_HI:`PDSR_DIAG_RSV2_LO]} : dctl_q;

  // Cable test engine; a fresh start beats a completion in the same cycle
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      pdsr_pkg::PDSR_DIAG_IDLE: begin
        if (diag_start) st_d = pdsr_pkg::PDSR_DIAG_RUN;
      end
      pdsr_pkg::PDSR_DIAG_RUN: begin
        if (diag_stop) st_d = pdsr_pkg::PDSR_DIAG_IDLE;
        else if (diag_start) st_d = pdsr_pkg::PDSR_DIAG_RUN;
        else if (diag_ans.done) st_d = pdsr_pkg::PDSR_DIAG_IDLE;
      end
      default: st_d = pdsr_pkg::PDSR_DIAG_IDLE;
    endcase
  end

  // Reserved result code is never shown: the last valid result stays
  assign res_d = (finished && !diag_start && diag_ans.result != `PDSR_RES_RSVD) ?
    diag_ans.result : res_q;

  // Saturating counter; a read subtracts what it returned so no frame is lost
  assign frame_bad = line_rx.valid && line_rx.last && (ferr_q || line_rx.err);
  assign cnt_sum = {1'b0, cnt_q} - {1'b0, (rd_clr ? clr_val : `PDSR_CNT_RST)}
    + {16'h0000, frame_bad};
  assign cnt_d = cnt_sum[16] ? `PDSR_CNT_MAX : cnt_sum[15:0];

  // ----------------------------------------------------------------------------
  // State flops
  // ----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lb_q <= `PDSR_LB_RST;
      st_q <= pdsr_pkg::PDSR_DIAG_IDLE;
      dctl_q <= {1'b0, `PDSR_PAIR_RST, 2'b00};
      res_q <= `PDSR_RES_NONE;
      cnt_q <= `PDSR_CNT_RST;
    end else begin
      lb_q <= lb_d;
      st_q <= st_d;
      dctl_q <= dctl_d;
      res_q <= res_d;
      cnt_q <= cnt_d;
    end
  end

  // Frame error tracking and link sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ferr_q <= 1'b0;
      link_q <= 2'h0;
    end else begin
      if (line_rx.valid) ferr_q <= line_rx.err && !line_rx.last;
      link_q <= {link_gig, link_fast};
    end
  end

  // ----------------------------------------------------------------------------
  // Read mux and outputs
  // ----------------------------------------------------------------------------
  wire [15:0] cap_word = (16'h0001 << `PDSR_CAP_TFD_BIT) | (16'h0001 << `PDSR_CAP_THD_BIT);
  wire [15:0] diag_word = {(st_q == pdsr_pkg::PDSR_DIAG_RUN), dctl_q, res_q, 8'h00};
  always_comb begin
    rd_hit = 1'b1;
    unique case (wreq.idx)
      `PDSR_IDX_EXT_CAP: rd_data = cap_word;
      `PDSR_IDX_LOOPBACK: rd_data = lb_q;
      `PDSR_IDX_CABLE_DIAG: rd_data = diag_word;
      `PDSR_IDX_LINE_LINK: rd_data = {14'h0000, link_q};
      `PDSR_IDX_RX_SYM_ERR: rd_data = cnt_q;
      default: begin
        rd_data = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign loop_en = lb_q[`PDSR_LB_BIT];
  assign diag_run = (st_q == pdsr_pkg::PDSR_DIAG_RUN);
  assign diag_pair = dctl_q[3:2];
  assign events[`PDSR_EV_DIAG_DONE] = finished && !diag_start && !diag_stop;
  assign events[`PDSR_EV_LINK_CHG] = (link_q != {link_gig, link_fast});
  assign events[`PDSR_EV_CNT_SAT] = cnt_sum[16] && !rd_clr;

endmodule : pdsr_port

// ===== bench/pdsr_props.sv
// Top-level assertions, bound to pdsr_top, for the diagnostic/status register bank
`timescale 1ns/100ps
`include "pdsr_defs.svh"
module pdsr_props #(
  parameter int NPORT = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Port side
  input wire logic [NPORT-1:0] diag_run,
  input pdsr_pkg::pdsr_diag_ans_t [NPORT-1:0] diag_ans,
  input pdsr_pkg::pdsr_beat_t [NPORT-1:0] line_rx,
  input pdsr_pkg::pdsr_beat_t [NPORT-1:0] line_tx,
  input pdsr_pkg::pdsr_beat_t [NPORT-1:0] fab_tx,
  input pdsr_pkg::pdsr_beat_t [NPORT-1:0] fab_rx
);
  // -------
  // Checks
  // -------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Read completing on a copper port register
  wire rd_end = psel && penable && pready && !pwrite;
  wire port_ok = (paddr[17:14] >= `PDSR_PORT_FIRST) && (paddr[17:14] <= `PDSR_PORT_LAST);
  ack_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ack after setup");
  ack_one_cycle_a: assert property (pready |=> !pready)
    else $error("ack longer than one cycle");
  ack_has_cause_a: assert property (pready |-> $past(psel && !penable))
    else $error("ack without setup");
  err_with_ack_a: assert property (pslverr |-> pready)
    else $error("error without ack");
  upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  cap_word_a: assert property (
    rd_end && port_ok && paddr[13:2] == `PDSR_IDX_EXT_CAP |-> prdata[15:0] == 16'h3000)
    else $error("capability word wrong");
  link_spare_a: assert property (
    rd_end && port_ok && paddr[13:2] == `PDSR_IDX_LINE_LINK |-> prdata[15:2] == 14'h0)
    else $error("link word spare bits set");
  result_code_a: assert property (
    rd_end && port_ok && paddr[13:2] == `PDSR_IDX_CABLE_DIAG |-> prdata[9:8] != 2'h3)
    else $error("reserved result shown");
  tx_source_a: assert property (
    line_tx[0] == $past(line_rx[0]) || line_tx[0] == $past(fab_tx[0]))
    else $error("line output from no source");
  rx_from_line_a: assert property (fab_rx[0] != '0 |-> fab_rx[0] == $past(line_rx[0]))
    else $error("fabric input not from line");
  diag_stop_a: assert property (
    diag_ans[0].done && diag_run[0] && !psel |-> ##[1:2] !diag_run[0])
    else $error("test did not stop on done");
endmodule : pdsr_props

bind pdsr_top pdsr_props #(.NPORT(NPORT)) props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .diag_run(diag_run), .diag_ans(diag_ans), .line_rx(line_rx), .line_tx(line_tx),
  .fab_tx(fab_tx), .fab_rx(fab_rx)
);

// ===== bench/test_phy_diag_status_regs.sv
// Self-checking bench for the diagnostic/status register bank
`timescale 1ns/100ps
`include "pdsr_defs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value t=%0t got %h exp %h", $time, (a), (b)); end end
module test_phy_diag_status_regs;
  // -------
  // Signals
  // -------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, er;
  logic [1:0] diag_run;
  logic [3:0] diag_pair, pn;
  logic [1:0] link_gig = '0;
  logic [1:0] link_fast = '0;
  logic [1:0] pr, r;
  logic [1:0] res_m[2] = '{2'h0, 2'h0};
  logic [2:0] lm;
  pdsr_pkg::pdsr_diag_ans_t [1:0] diag_ans = '0;
  pdsr_pkg::pdsr_beat_t [1:0] line_rx = '0;
  pdsr_pkg::pdsr_beat_t [1:0] fab_tx = '0;
  pdsr_pkg::pdsr_beat_t [1:0] line_tx, fab_rx;
  pdsr_pkg::pdsr_beat_t xmac_txd = '0;
  pdsr_pkg::pdsr_beat_t xfab_tx = '0;
  pdsr_pkg::pdsr_beat_t xmac_rxd, xfab_rx, b, f, t, xf;
  logic [31:0] rs = 32'hf37f;
  int error_cnt = 0;
  int n_tests = 0;
  int p, cnt_m;

  // Byte lanes are always all enabled; lane masking is not exercised
  pdsr_top #(.NPORT(2)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .diag_run(diag_run), .diag_pair(diag_pair),
    .diag_ans(diag_ans), .link_gig(link_gig), .link_fast(link_fast), .line_rx(line_rx),
    .line_tx(line_tx), .fab_tx(fab_tx), .fab_rx(fab_rx), .xmac_txd(xmac_txd),
    .xmac_rxd(xmac_rxd), .xfab_tx(xfab_tx), .xfab_rx(xfab_rx)
  );

  // 200 MHz clock
  initial begin
    forever #2.5 pclk = ~pclk;
  end

  // -------
  // Helpers
  // -------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  // One APB transfer; waits for pready under a bound, never a fixed count
  task automatic apb(input logic w, input logic [15:0] idx, input logic [15:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      $display("wrong value t=%0t no bus answer", $time);
      error_cnt++;
      report_and_stop();
    end
  endtask : apb

  task automatic rd_is(input logic [15:0] idx, input logic [15:0] exp);
    apb(1'b0, idx, 16'h0000);
    `CHK(rd, {16'h0000, exp})
    `CHK(er, 1'b0)
  endtask : rd_is

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : tick

  // Random beats on every path; err and last stay low so no frame is counted
  task automatic beats(input logic [2:0] m);
    repeat (6) begin
      rs = lfsr(rs);
      b = {rs[8], 2'b00, rs[7:0]};
      f = {rs[9], 2'b00, rs[15:8]};
      t = {rs[10], 2'b00, rs[23:16]};
      xf = {rs[11], 2'b00, rs[31:24]};
      @(posedge pclk);
      line_rx <= {b, b};
      fab_tx <= {f, f};
      xmac_txd <= t;
      xfab_tx <= xf;
      tick(1);
      for (int q = 0; q < 2; q++) begin
        `CHK(line_tx[q], m[q] ? b : f)
        `CHK(fab_rx[q], m[q] ? 11'h000 : b)
      end
      `CHK(xmac_rxd, m[2] ? t : xf)
      `CHK(xfab_rx, m[2] ? 11'h000 : t)
    end
  endtask : beats

  // ---------
  // Scenarios
  // ---------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int q = 1; q < 3; q++) begin
      pn = 4'(q);
      rd_is({pn, `PDSR_IDX_EXT_CAP}, 16'h3000);
      apb(1'b1, {pn, `PDSR_IDX_EXT_CAP}, 16'h0000);
      rd_is({pn, `PDSR_IDX_EXT_CAP}, 16'h3000);
      rd_is({pn, `PDSR_IDX_LOOPBACK}, `PDSR_LB_RST);
      rd_is({pn, `PDSR_IDX_CABLE_DIAG}, 16'h0000);
      rd_is({pn, `PDSR_IDX_RX_SYM_ERR}, `PDSR_CNT_RST);
    end
    apb(1'b1, {4'h1, `PDSR_IDX_LOOPBACK}, 16'hfeff);
    rd_is({4'h1, `PDSR_IDX_LOOPBACK}, 16'hfefc);
    apb(1'b0, 16'h3124, 16'h0000);
    `CHK(er, 1'b1)
    `CHK(rd, 32'h0)
    $display("test reset and map done");
    for (int j = 0; j < 4; j++) begin
      lm = 3'(1 << j);
      apb(1'b1, {4'h1, `PDSR_IDX_LOOPBACK}, {7'h00, lm[0], 8'hf4});
      apb(1'b1, {4'h2, `PDSR_IDX_LOOPBACK}, {7'h00, lm[1], 8'hf4});
      apb(1'b1, `PDSR_IDX_XMAC_LOOPBACK, {7'h00, lm[2], 8'hf4});
      rd_is({4'h2, `PDSR_IDX_LOOPBACK}, {7'h00, lm[1], 8'hf4});
      beats(lm);
    end
    $display("test loopback done");
    for (int c = 0; c < 4; c++) begin
      @(posedge pclk);
      link_gig <= {c[0], c[1]};
      link_fast <= {c[1], c[0]};
      tick(2);
      rd_is({4'h1, `PDSR_IDX_LINE_LINK}, {14'h0, c[1], c[0]});
      rd_is({4'h2, `PDSR_IDX_LINE_LINK}, {14'h0, c[0], c[1]});
    end
    $display("test link status done");
    apb(1'b1, `PDSR_IDX_IRQ_STATUS, 16'hffff);
    apb(1'b1, `PDSR_IDX_IRQ_MASK, 16'h0009);
    for (int i = 0; i < 8; i++) begin
      p = i % 2;
      pr = 2'(i / 2);
      r = (i == 7) ? 2'h3 : 2'(i % 3);
      pn = 4'(p + 1);
      apb(1'b1, {pn, `PDSR_IDX_CABLE_DIAG}, {2'b10, pr, 12'h000});
      tick(2);
      `CHK(diag_run[p], 1'b1)
      `CHK(diag_pair[2*p+:2], pr)
      rd_is({pn, `PDSR_IDX_CABLE_DIAG}, {2'b10, pr, 2'b00, res_m[p], 8'h00});
      @(posedge pclk);
      diag_ans[p] <= {1'b1, r};
      @(posedge pclk);
      diag_ans[p] <= 3'h0;
      if (r != 2'h3) res_m[p] = r;
      tick(2);
      `CHK(diag_run[p], 1'b0)
      `CHK(irq, 1'b1)
      rd_is({pn, `PDSR_IDX_CABLE_DIAG}, {4'h0 | pr, 2'b00, res_m[p], 8'h00});
      apb(1'b1, `PDSR_IDX_IRQ_STATUS, 16'h0009);
      tick(1);
      `CHK(irq, 1'b0)
    end
    apb(1'b1, {4'h1, `PDSR_IDX_CABLE_DIAG}, 16'h8000);
    tick(2);
    `CHK(diag_run[0], 1'b1)
    apb(1'b1, {4'h1, `PDSR_IDX_CABLE_DIAG}, 16'h0000);
    tick(2);
    `CHK(diag_run[0], 1'b0)
    rd_is({4'h1, `PDSR_IDX_CABLE_DIAG}, {6'h00, res_m[0], 8'h00});
    $display("test cable diagnostic done");
    // Two-beat frames with the error on the first beat, then one clean frame
    for (int q = 0; q < 2; q++) begin
      rs = lfsr(rs);
      cnt_m = int'(rs[2:0]) + 1;
      repeat (cnt_m) begin
        @(posedge pclk);
        line_rx[q] <= 11'h500;
        @(posedge pclk);
        line_rx[q] <= 11'h600;
      end
      @(posedge pclk);
      line_rx[q] <= 11'h600;
      @(posedge pclk);
      line_rx[q] <= 11'h000;
      tick(2);
      rd_is({4'(q + 1), `PDSR_IDX_RX_SYM_ERR}, 16'(cnt_m));
      rd_is({4'(q + 1), `PDSR_IDX_RX_SYM_ERR}, 16'h0000);
    end
    apb(1'b1, `PDSR_IDX_IRQ_MASK, 16'h0004);
    @(posedge pclk);
    line_rx[0] <= 11'h700;
    repeat (65540) @(posedge pclk);
    line_rx[0] <= 11'h000;
    tick(2);
    `CHK(irq, 1'b1)
    rd_is({4'h1, `PDSR_IDX_RX_SYM_ERR}, `PDSR_CNT_MAX);
    apb(1'b1, `PDSR_IDX_IRQ_STATUS, 16'h0004);
    tick(1);
    `CHK(irq, 1'b0)
    $display("test error counter done");
    report_and_stop();
  end
endmodule : test_phy_diag_status_regs
